/* hdl/pts_apb.sv */
// apb slave front end, wait state free access
`timescale 1ns/1ps
module pts_apb (
  input  wire logic                        pclk,     // system clock
  input  wire logic                        presetn,  // async reset, active low
  input  wire logic                        psel,     // slave select
  input  wire logic                        penable,  // access phase
  input  wire logic                        pwrite,   // write when high
  input  wire logic [pts_pkg::PTS_AW-1:0]  paddr,    // byte address
  input  wire logic [pts_pkg::PTS_DW-1:0]  pwdata,   // write data
  output logic      [pts_pkg::PTS_DW-1:0]  prdata,   // read data
  output logic                             pready,   // access complete
  output logic                             pslverr,  // unmapped address
  pts_reg_if.bus                           rif       // register side
);
  import pts_pkg::*;

  assign rif.addr  = paddr;
  assign rif.wdata = pwdata;
  // write lands on the edge that closes the access phase
  assign rif.wr    = psel && penable && pready && pwrite;

  // ready rises for the access phase right after each setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= pwrite ? '0 : rif.rdata;
      pslverr <= !rif.hit;
    end
  end
endmodule

/* hdl/pts_pkg.sv */
// constants and types shared by the trip source select block
package pts_pkg;

  localparam int          PTS_AW        = 8;
  localparam int          PTS_DW        = 32;
  localparam int          PTS_NUM_TRIP  = 6;
  localparam int          PTS_SYNC_LEN  = 3;

  // register byte offsets
  localparam logic [7:0]  PTS_OFF_SEL   = 8'h00;
  localparam logic [7:0]  PTS_OFF_ACT   = 8'h04;
  localparam logic [7:0]  PTS_OFF_CLR   = 8'h08;
  localparam logic [7:0]  PTS_OFF_STAT  = 8'h0C;
  localparam logic [7:0]  PTS_OFF_MASK  = 8'h10;
  localparam logic [7:0]  PTS_OFF_STATE = 8'h14;

  // trip_source_select layout
  localparam int          PTS_SEL_W         = 16;
  localparam int          PTS_SEL_CYC_LSB   = 0;
  localparam int          PTS_SEL_LAT_LSB   = 8;
  localparam logic [15:0] PTS_SEL_MASK      = 16'h3F3F;
  localparam logic [15:0] PTS_SEL_RESET     = 16'h0000;

  // trip_action_control layout
  localparam int          PTS_ACT_W         = 4;
  localparam int          PTS_ACT_A_LSB     = 0;
  localparam int          PTS_ACT_B_LSB     = 2;
  localparam logic [3:0]  PTS_ACT_RESET     = 4'h0;

  // action codes
  typedef logic [1:0] pts_action_type;
  localparam pts_action_type PTS_ACT_HIZ    = 2'h0;
  localparam pts_action_type PTS_ACT_HIGH   = 2'h1;
  localparam pts_action_type PTS_ACT_LOW    = 2'h2;
  localparam pts_action_type PTS_ACT_KEEP   = 2'h3;

  // flag layout shared by clear, status, mask and state registers
  localparam int          PTS_FLG_W         = 3;
  localparam int          PTS_FLG_CYC       = 1;
  localparam int          PTS_FLG_LAT       = 2;
  localparam logic [2:0]  PTS_FLG_MASK      = 3'h6;
  localparam logic [2:0]  PTS_FLG_RESET     = 3'h0;

endpackage

/* hdl/pts_reg_if.sv */
// register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface pts_reg_if;
  import pts_pkg::*;
  logic              wr;
  logic [PTS_AW-1:0] addr;
  logic [PTS_DW-1:0] wdata;
  logic [PTS_DW-1:0] rdata;
  logic              hit;

  modport bus  (output wr, addr, wdata, input  rdata, hit);
  modport regs (input  wr, addr, wdata, output rdata, hit);
endinterface

/* hdl/pts_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pts_sync #(
  parameter int           W       = 6,
  parameter logic [5:0]   RST_VAL = 6'h3F
) (
  input  wire logic         pclk,     // system clock
  input  wire logic         presetn,  // async reset, active low
  input  wire logic [W-1:0] pin_in,   // raw asynchronous pins
  output logic      [W-1:0] pin_out   // filtered synchronous level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= RST_VAL[W-1:0];
      s2_r <= RST_VAL[W-1:0];
      s3_r <= RST_VAL[W-1:0];
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change is taken only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pin_out[i] <= RST_VAL[i];
        else if (s2_r[i] == s3_r[i])
          pin_out[i] <= s3_r[i];
      end
    end
  endgenerate
endmodule

/* hdl/pts_top.sv */
// trip source selection, trip latches, output override and registers
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module pts_top #(
  parameter int NUM_TRIP = pts_pkg::PTS_NUM_TRIP
) (
  input  wire logic                        pclk,          // system clock, 125 MHz
  input  wire logic                        presetn,       // async reset, active low
  input  wire logic                        psel,          // apb select
  input  wire logic                        penable,       // apb access phase
  input  wire logic                        pwrite,        // apb direction
  input  wire logic [pts_pkg::PTS_AW-1:0]  paddr,         // apb byte address
  input  wire logic [pts_pkg::PTS_DW-1:0]  pwdata,        // apb write data
  output logic      [pts_pkg::PTS_DW-1:0]  prdata,        // apb read data
  output logic                             pready,        // apb ready
  output logic                             pslverr,       // apb error
  input  wire logic [NUM_TRIP-1:0]         fault_input_n, // trip pins, active low
  input  wire logic                        ctr_zero,      // time-base counter at zero
  input  wire logic                        pwm_in_a,      // pwm a before trip override
  input  wire logic                        pwm_in_b,      // pwm b before trip override
  output logic                             pwm_out_a,     // pwm a pin level
  output logic                             pwm_out_a_oe,  // pwm a drive enable
  output logic                             pwm_out_b,     // pwm b pin level
  output logic                             pwm_out_b_oe,  // pwm b drive enable
  output logic                             trip_irq       // interrupt, level high
);
  import pts_pkg::*;

  pts_reg_if rif ();

  logic [PTS_SEL_W-1:0] sel_r;
  logic [PTS_ACT_W-1:0] act_r;
  logic [PTS_FLG_W-1:0] stat_r;
  logic [PTS_FLG_W-1:0] mask_r;
  logic                 lat_trip_r;
  logic                 cyc_trip_r;
  logic [NUM_TRIP-1:0]  fault_sync;
  logic [NUM_TRIP-1:0]  lat_en;
  logic [NUM_TRIP-1:0]  cyc_en;
  logic [NUM_TRIP-1:0]  lat_hit_bit;
  logic [NUM_TRIP-1:0]  cyc_hit_bit;
  logic                 lat_hit;
  logic                 cyc_hit;
  logic                 any_trip;
  logic                 wr_sel;
  logic                 wr_act;
  logic                 wr_clr;
  logic                 wr_stat;
  logic                 wr_mask;
  logic [PTS_FLG_W-1:0] wflg;
  logic [PTS_FLG_W-1:0] stat_nxt;
  logic [1:0]           drv_a_nxt;
  logic [1:0]           drv_b_nxt;

  pts_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif.bus)
  );

  pts_sync #(
    .W       (NUM_TRIP),
    .RST_VAL (6'h3F)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (fault_input_n),
    .pin_out (fault_sync)
  );

  // write strobes
  assign wflg    = rif.wdata[PTS_FLG_W-1:0] & PTS_FLG_MASK;
  assign wr_sel  = rif.wr && (rif.addr == PTS_OFF_SEL);
  assign wr_act  = rif.wr && (rif.addr == PTS_OFF_ACT);
  assign wr_clr  = rif.wr && (rif.addr == PTS_OFF_CLR);
  assign wr_stat = rif.wr && (rif.addr == PTS_OFF_STAT);
  assign wr_mask = rif.wr && (rif.addr == PTS_OFF_MASK);

  // read decode
  always_comb
  begin
    rif.rdata = '0;
    rif.hit   = 1'b1;
    if (rif.addr == PTS_OFF_SEL)
      rif.rdata[PTS_SEL_W-1:0] = sel_r;
    else if (rif.addr == PTS_OFF_ACT)
      rif.rdata[PTS_ACT_W-1:0] = act_r;
    else if (rif.addr == PTS_OFF_CLR)
      rif.rdata = '0;
    else if (rif.addr == PTS_OFF_STAT)
      rif.rdata[PTS_FLG_W-1:0] = stat_r;
    else if (rif.addr == PTS_OFF_MASK)
      rif.rdata[PTS_FLG_W-1:0] = mask_r;
    else if (rif.addr == PTS_OFF_STATE)
    begin
      rif.rdata[PTS_FLG_CYC] = cyc_trip_r;
      rif.rdata[PTS_FLG_LAT] = lat_trip_r;
    end
    else
      rif.hit = 1'b0;
  end

  // source select register; reserved bits are masked off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_r <= PTS_SEL_RESET;
    else if (wr_sel)
      sel_r <= rif.wdata[PTS_SEL_W-1:0] & PTS_SEL_MASK;
  end

  // action control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_r <= PTS_ACT_RESET;
    else if (wr_act)
      act_r <= rif.wdata[PTS_ACT_W-1:0];
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= PTS_FLG_RESET;
    else if (wr_mask)
      mask_r <= wflg;
  end

  // per-input enables and hit detection
  genvar i;
  generate
    for (i = 0; i < NUM_TRIP; i++)
    begin : g_src
      // bits 8..13 pick latched sources for inputs 1..6
      assign lat_en[i]      = sel_r[PTS_SEL_LAT_LSB + i];
      // bits 0..5 pick per-cycle sources for inputs 1..6
      assign cyc_en[i]      = sel_r[PTS_SEL_CYC_LSB + i];
      assign lat_hit_bit[i] = lat_en[i] && !fault_sync[i];
      assign cyc_hit_bit[i] = cyc_en[i] && !fault_sync[i];
    end
  endgenerate

  assign lat_hit  = |lat_hit_bit;
  assign cyc_hit  = |cyc_hit_bit;
  assign any_trip = lat_trip_r || cyc_trip_r;

  // latched trip: held until software clears it, a new hit wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lat_trip_r <= 1'b0;
    else if (lat_hit)
      lat_trip_r <= 1'b1;
    else if (wr_clr && wflg[PTS_FLG_LAT])
      lat_trip_r <= 1'b0;
  end

  // per-cycle trip: dropped at counter zero unless still hit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc_trip_r <= 1'b0;
    else if (cyc_hit)
      cyc_trip_r <= 1'b1;
    else if (ctr_zero)
      cyc_trip_r <= 1'b0;
  end

  // sticky event flags, write one to clear, set wins
  always_comb
  begin
    stat_nxt = stat_r;
    if (wr_stat)
      stat_nxt = stat_r & ~wflg;
    if (cyc_hit)
      stat_nxt[PTS_FLG_CYC] = 1'b1;
    if (lat_hit)
      stat_nxt[PTS_FLG_LAT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= PTS_FLG_RESET;
    else
      stat_r <= stat_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trip_irq <= 1'b0;
    else
      trip_irq <= |(stat_r & mask_r);
  end

  // returns {drive enable, level} for one output
  function automatic logic [1:0] pts_drive(
    input logic           tripped,
    input pts_action_type code,
    input logic           level
  );
    logic [1:0] res;
    res = {1'b1, level};
    if (tripped)
    begin
      case (code)
        PTS_ACT_HIZ:  res = 2'b00;
        PTS_ACT_HIGH: res = 2'b11;
        PTS_ACT_LOW:  res = 2'b10;
        default:      res = {1'b1, level};
      endcase
    end
    return res;
  endfunction

  // same trip state overrides both outputs
  assign drv_a_nxt = pts_drive(any_trip, act_r[PTS_ACT_A_LSB +: 2], pwm_in_a);
  assign drv_b_nxt = pts_drive(any_trip, act_r[PTS_ACT_B_LSB +: 2], pwm_in_b);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_out_a    <= 1'b0;
      pwm_out_a_oe <= 1'b0;
      pwm_out_b    <= 1'b0;
      pwm_out_b_oe <= 1'b0;
    end
    else
    begin
      pwm_out_a_oe <= drv_a_nxt[1];
      pwm_out_a    <= drv_a_nxt[0];
      pwm_out_b_oe <= drv_b_nxt[1];
      pwm_out_b    <= drv_b_nxt[0];
    end
  end
endmodule

/* tb/pts_fault_src.sv */
// fault pin source: pulled-up trip pins driven low on command
`timescale 1ns/1ps
module pts_fault_src (
  input  wire logic [5:0] pull_low,      // pins to drive low
  output logic      [5:0] fault_input_n  // trip pins, idle high
);
  assign fault_input_n = ~pull_low;
endmodule

/* tb/pts_top_chk.sv */
// port checker for the trip source select top
`timescale 1ns/1ps
module pts_top_chk
  import pts_pkg::*;
#(
  parameter int NUM_TRIP = pts_pkg::PTS_NUM_TRIP
) (
  input wire logic                 pclk,          // clock
  input wire logic                 presetn,       // reset
  input wire logic                 psel,          // select
  input wire logic                 penable,       // access
  input wire logic                 pwrite,        // write
  input wire logic [PTS_AW-1:0]    paddr,         // address
  input wire logic [PTS_DW-1:0]    pwdata,        // wdata
  input wire logic [PTS_DW-1:0]    prdata,        // rdata
  input wire logic                 pready,        // ready
  input wire logic                 pslverr,       // error
  input wire logic [NUM_TRIP-1:0]  fault_input_n, // pins
  input wire logic                 ctr_zero,      // zero
  input wire logic                 pwm_in_a,      // in a
  input wire logic                 pwm_in_b,      // in b
  input wire logic                 pwm_out_a,     // out a
  input wire logic                 pwm_out_a_oe,  // oe a
  input wire logic                 pwm_out_b,     // out b
  input wire logic                 pwm_out_b_oe,  // oe b
  input wire logic                 trip_irq       // irq
);
  logic [3:0] act_r;
  // mirror of the action register, taken from completed writes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      act_r <= 4'h0;
    else if (psel && penable && pready && pwrite && paddr == PTS_OFF_ACT)
      act_r <= pwdata[3:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  err_map_a: assert property (psel && !penable |=> pslverr == ($past(paddr) > PTS_OFF_STATE
    || $past(paddr[1:0]) != 2'h0)) else $error("error flag wrong");
  sel_rsvd_a: assert property (psel && !penable && !pwrite && paddr == PTS_OFF_SEL
    |=> prdata[15:14] == 2'h0 && prdata[7:6] == 2'h0) else $error("reserved select bits set");
  hiz_a_cause_a: assert property (!pwm_out_a_oe |-> $past(act_r[1:0]) == PTS_ACT_HIZ)
    else $error("out a released without hiz code");
  hiz_b_cause_a: assert property (!pwm_out_b_oe |-> $past(act_r[3:2]) == PTS_ACT_HIZ)
    else $error("out b released without hiz code");
  force_a_a: assert property (pwm_out_a_oe && pwm_out_a != $past(pwm_in_a) && $past(act_r[1:0]) != PTS_ACT_KEEP
    |-> $past(act_r[1:0]) == (pwm_out_a ? PTS_ACT_HIGH : PTS_ACT_LOW)) else $error("out a forced wrongly");
  cover property (pslverr);
  cover property (!pwm_out_a_oe);
  cover property (trip_irq);
endmodule

bind pts_top pts_top_chk #(.NUM_TRIP(NUM_TRIP)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fault_input_n(fault_input_n), .ctr_zero(ctr_zero), .pwm_in_a(pwm_in_a),
  .pwm_in_b(pwm_in_b), .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b),
  .pwm_out_b_oe(pwm_out_b_oe), .trip_irq(trip_irq));

/* tb/pwm_trip_source_select_test.sv */
// self-checking bench for the trip source select block
`timescale 1ns/1ps
module pwm_trip_source_select_test;
  import pts_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ctr_zero, pwm_in_a, pwm_in_b;
  logic        pready, pslverr, oa, ea, ob, eb, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  pull_low, flt_n;
  int          err_total, cmp_count, cyc;

  pts_fault_src src (.pull_low(pull_low), .fault_input_n(flt_n));
  pts_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_input_n(flt_n), .ctr_zero(ctr_zero), .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b),
    .pwm_out_a(oa), .pwm_out_a_oe(ea), .pwm_out_b(ob), .pwm_out_b_oe(eb), .trip_irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  // one apb transfer; waits for ready without assuming its latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pin(input logic [5:0] m, input int n);
    pull_low <= m;
    repeat (n) @(posedge pclk);
  endtask

  task automatic zero_pulse;
    @(posedge pclk);
    ctr_zero <= 1'b1;
    @(posedge pclk);
    ctr_zero <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic outs(input logic a, input logic b);
    chk("pwm outputs", {28'h0, 1'b1, a, 1'b1, b}, {28'h0, ea, oa, eb, ob});
  endtask

  task automatic t_regs;
    apb(1'b0, PTS_OFF_SEL, 32'h0000_0000);
    chk("select reset", 32'h0000_0000, rd);
    apb(1'b1, PTS_OFF_SEL, 32'hFFFF_FFFF);
    apb(1'b0, PTS_OFF_SEL, 32'h0000_0000);
    chk("select bits", 32'h0000_3F3F, rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, er});
  endtask

  task automatic t_latched;
    apb(1'b1, PTS_OFF_ACT, 32'h0000_0006);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, PTS_OFF_SEL, 32'h0000_0100 << i);
      pin(6'h01 << ((i + 1) % 6), 10);
      outs(1'b1, 1'b0);
      pin(6'h01 << i, 10);
      outs(1'b0, 1'b1);
      pin(6'h00, 10);
      zero_pulse();
      outs(1'b0, 1'b1);
      apb(1'b1, PTS_OFF_CLR, 32'h0000_0004);
      pin(6'h00, 4);
      outs(1'b1, 1'b0);
    end
  endtask

  task automatic t_cycle;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, PTS_OFF_SEL, 32'h0000_0001 << i);
      pin(6'h01 << i, 10);
      zero_pulse();
      outs(1'b0, 1'b1);
      pin(6'h00, 10);
      // pin released: the trip must persist until the counter reaches zero
      outs(1'b0, 1'b1);
      zero_pulse();
      outs(1'b1, 1'b0);
    end
  endtask

  task automatic t_action;
    apb(1'b1, PTS_OFF_SEL, 32'h0000_0100);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, PTS_OFF_ACT, 32'(c * 5));
      // inputs opposite to their idle levels, so forced high on a and forced low on b differ from the kept levels
      pwm_in_a <= 1'b0;
      pwm_in_b <= 1'b1;
      pin(6'h01, 10);
      chk("action", {28'h0, c > 0, c == 1, c > 0, c % 2 == 1}, {28'h0, ea, ea & oa, eb, eb & ob});
      pwm_in_a <= 1'b1;
      pwm_in_b <= 1'b0;
      pin(6'h00, 6);
      apb(1'b1, PTS_OFF_CLR, 32'h0000_0004);
    end
  endtask

  task automatic t_irq;
    apb(1'b1, PTS_OFF_STAT, 32'h0000_0006);
    apb(1'b1, PTS_OFF_MASK, 32'h0000_0004);
    pin(6'h01, 10);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    apb(1'b1, PTS_OFF_MASK, 32'h0000_0000);
    pin(6'h01, 3);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    apb(1'b0, PTS_OFF_STAT, 32'h0000_0000);
    chk("status", 32'h0000_0004, rd);
    pin(6'h00, 8);
    apb(1'b1, PTS_OFF_CLR, 32'h0000_0004);
    apb(1'b1, PTS_OFF_STAT, 32'h0000_0004);
    apb(1'b1, PTS_OFF_MASK, 32'h0000_0004);
    pin(6'h00, 3);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    apb(1'b0, PTS_OFF_STATE, 32'h0000_0000);
    chk("trip state", 32'h0000_0000, rd);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pull_low = 6'h00;
    ctr_zero = 1'b0;
    pwm_in_a = 1'b1;
    pwm_in_b = 1'b0;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_latched();
    t_cycle();
    t_action();
    t_irq();
    results();
  end
endmodule
